// File: design/rwdt_pkg.sv
// Purpose: shared constants and types of the runaway watchdog timer
// Assumes: one clock pclk at 200 MHz, registers reached over APB
// Notes: all offsets are byte addresses on a 32-bit APB
package rwdt_pkg;

  // counter geometry
  localparam int RWDT_CNT_W = 22;
  localparam int RWDT_TAP_BASE = 15;
  localparam int RWDT_TAP_STEP = 2;

  // apb register map, byte addresses
  localparam int RWDT_ADDR_W = 8;
  localparam logic [7:0] RWDT_OFF_MODE = 8'h00;
  localparam logic [7:0] RWDT_OFF_CMD = 8'h04;
  localparam logic [7:0] RWDT_OFF_STAT = 8'h08;
  localparam logic [7:0] RWDT_OFF_MASK = 8'h0c;
  localparam logic [7:0] RWDT_OFF_STATE = 8'h10;
  localparam logic [7:0] RWDT_OFF_COUNT = 8'h14;

  // mode control field positions
  localparam int RWDT_MODE_EN_BIT = 7;
  localparam int RWDT_MODE_TSEL_LO = 5;
  localparam int RWDT_MODE_I2RUN_BIT = 3;
  localparam int RWDT_MODE_RLINK_BIT = 1;
  localparam logic [7:0] RWDT_MODE_WMASK = 8'hea;

  // values after reset
  localparam logic [1:0] RWDT_TSEL_RST = 2'h0;
  localparam logic RWDT_EN_RST = 1'b1;
  localparam logic RWDT_I2RUN_RST = 1'b0;
  localparam logic RWDT_RLINK_RST = 1'b0;
  localparam logic [1:0] RWDT_STAT_RST = 2'h0;
  localparam logic [1:0] RWDT_MASK_RST = 2'h0;

  // command codes
  localparam logic [7:0] RWDT_CMD_CLEAR = 8'h4e;
  localparam logic [7:0] RWDT_CMD_DISABLE = 8'hb1;

  // interrupt status layout
  localparam int RWDT_ST_W = 2;
  localparam int RWDT_ST_OVF_BIT = 0;
  localparam int RWDT_ST_RST_BIT = 1;

  // internal reset length in system clock periods
  localparam int RWDT_RST_MIN_CYC = 22;
  localparam int RWDT_RST_MAX_CYC = 29;
  localparam int RWDT_RST_CYC = (RWDT_RST_MIN_CYC + RWDT_RST_MAX_CYC) / 2;
  localparam int RWDT_RST_CNT_W = 5;

  typedef enum logic [0:0] {
    RWDT_RUNNING = 1'b0,
    RWDT_DISABLED = 1'b1
  } rwdt_en_state_t;

  typedef enum logic [0:0] {
    RWDT_RST_IDLE = 1'b0,
    RWDT_RST_HOLD = 1'b1
  } rwdt_rst_state_t;

  // all-ones mask below the selected overflow tap
  function automatic logic [RWDT_CNT_W-1:0] rwdt_tap_mask(input logic [1:0] sel);
    logic [RWDT_CNT_W-1:0] one;
    one = {{(RWDT_CNT_W-1){1'b0}}, 1'b1};
    return (one << (RWDT_TAP_BASE + RWDT_TAP_STEP * int'(sel))) - one;
  endfunction

endpackage

// File: design/rwdt_if.sv
// Purpose: carrier between the watchdog control and its counter and reset stretcher
// Assumes: all signals on pclk
// Notes: no clocking block
`timescale 1ns/100ps
interface rwdt_if;
  logic run;
  logic clear;
  logic [1:0] tsel;
  logic overflow;
  logic [rwdt_pkg::RWDT_CNT_W-1:0] count;
  logic rst_trig;
  logic rst_busy;
  logic sys_rst;

  modport ctl (output run, clear, tsel, rst_trig, input overflow, count, rst_busy, sys_rst);
  modport cnt (input run, clear, tsel, output overflow, count);
  modport rst (input rst_trig, output rst_busy, sys_rst);
endinterface

// File: design/rwdt_counter.sv
// Purpose: 22-stage binary counter with selectable overflow tap
// Assumes: run and clear come from logic on pclk
// Notes: overflow is a one-cycle pulse each time the selected tap is passed
`timescale 1ns/100ps
module rwdt_counter (
  input wire logic pclk,
  input wire logic presetn,
  rwdt_if.cnt cif
);

  logic [rwdt_pkg::RWDT_CNT_W-1:0] cnt_r;
  logic [rwdt_pkg::RWDT_CNT_W-1:0] tap_mask;
  logic ovf_r;

  // mask of the bits below the chosen tap
  assign tap_mask = rwdt_pkg::rwdt_tap_mask(cif.tsel);

  // counting, clear restarts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cif.clear) begin
      cnt_r <= '0;
    end else if (cif.run) begin
      cnt_r <= cnt_r + {{(rwdt_pkg::RWDT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // overflow pulse registered from the last count before the tap, high in the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= cif.run && !cif.clear && ((cnt_r & tap_mask) == tap_mask);
    end
  end

  assign cif.overflow = ovf_r;
  assign cif.count = cnt_r;

endmodule

// File: design/rwdt_rst_stretch.sv
// Purpose: stretches an overflow into a fixed-length internal reset
// Assumes: trigger is a pulse on pclk
// Notes: triggers during a running reset are ignored
`timescale 1ns/100ps
module rwdt_rst_stretch (
  input wire logic pclk,
  input wire logic presetn,
  rwdt_if.rst rif
);

  rwdt_pkg::rwdt_rst_state_t state_r;
  logic [rwdt_pkg::RWDT_RST_CNT_W-1:0] left_r;

  // hold for the fixed number of system clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rwdt_pkg::RWDT_RST_IDLE;
      left_r <= '0;
    end else begin
      case (state_r)
        rwdt_pkg::RWDT_RST_IDLE: begin
          if (rif.rst_trig) begin
            state_r <= rwdt_pkg::RWDT_RST_HOLD;
            left_r <= rwdt_pkg::RWDT_RST_CNT_W'(rwdt_pkg::RWDT_RST_CYC - 1);
          end
        end
        rwdt_pkg::RWDT_RST_HOLD: begin
          if (left_r == '0) begin
            state_r <= rwdt_pkg::RWDT_RST_IDLE;
          end else begin
            left_r <= left_r - 1'b1;
          end
        end
        default: begin
          state_r <= rwdt_pkg::RWDT_RST_IDLE;
        end
      endcase
    end
  end

  assign rif.sys_rst = (state_r == rwdt_pkg::RWDT_RST_HOLD);
  assign rif.rst_busy = (state_r == rwdt_pkg::RWDT_RST_HOLD);

endmodule

// File: design/rwdt_top.sv
// Purpose: runaway watchdog timer with apb registers, nmi and internal reset
// Assumes: low-power mode inputs come from the power controller on pclk
// Notes: internal_reset is a separate output and never touches the reset pin
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module rwdt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rwdt_pkg::RWDT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_level_one,
  input wire logic idle_level_two,
  input wire logic stop_mode,
  output logic watchdog_nmi_request,
  output logic irq,
  output logic internal_reset
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  rwdt_if wif ();

  logic [1:0] timeout_select_r;
  logic watchdog_enable_bit_r;
  logic idle_two_run_enable_r;
  logic reset_link_bit_r;
  rwdt_pkg::rwdt_en_state_t en_state_r;
  logic [rwdt_pkg::RWDT_ST_W-1:0] stat_r;
  logic [rwdt_pkg::RWDT_ST_W-1:0] mask_r;
  logic [rwdt_pkg::RWDT_ST_W-1:0] stat_nxt;
  logic [rwdt_pkg::RWDT_ST_W-1:0] mask_nxt;
  logic nmi_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_word;
  logic [31:0] state_word;
  logic [5:0] reg_sel;
  logic [7:0] cmd_byte;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic wr_mode;
  logic wr_cmd;
  logic wr_stat;
  logic wr_mask;
  logic cmd_clear;
  logic cmd_disable;
  logic halted;
  logic deep_halt;
  logic idle_two_halt;
  logic active;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // one-hot select: mode, command, status, mask, state, count; zero for a hole
  function automatic logic [5:0] rwdt_reg_sel(input logic [rwdt_pkg::RWDT_ADDR_W-1:0] a);
    logic [5:0] s;
    s = 6'h00;
    s[0] = (a == rwdt_pkg::RWDT_OFF_MODE);
    s[1] = (a == rwdt_pkg::RWDT_OFF_CMD);
    s[2] = (a == rwdt_pkg::RWDT_OFF_STAT);
    s[3] = (a == rwdt_pkg::RWDT_OFF_MASK);
    s[4] = (a == rwdt_pkg::RWDT_OFF_STATE);
    s[5] = (a == rwdt_pkg::RWDT_OFF_COUNT);
    return s;
  endfunction

  // write qualifier in the access phase, read qualifier in either phase, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign reg_sel = rwdt_reg_sel(paddr);
  assign mapped = |reg_sel;

  // per-register write strobes
  assign wr_mode = wr_en && reg_sel[0];
  assign wr_cmd = wr_en && reg_sel[1];
  assign wr_stat = wr_en && reg_sel[2];
  assign wr_mask = wr_en && reg_sel[3];

  // only the two codes are recognised, in the low byte
  assign cmd_byte = pwdata[7:0];
  assign cmd_clear = wr_cmd && (cmd_byte == rwdt_pkg::RWDT_CMD_CLEAR);
  assign cmd_disable = wr_cmd && (cmd_byte == rwdt_pkg::RWDT_CMD_DISABLE);

  // bus answer
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // mode control register

  // timeout select field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_select_r <= rwdt_pkg::RWDT_TSEL_RST;
    end else if (wr_mode) begin
      timeout_select_r <= pwdata[rwdt_pkg::RWDT_MODE_TSEL_LO +: 2];
    end
  end

  // enable bit, active out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_enable_bit_r <= rwdt_pkg::RWDT_EN_RST;
    end else if (wr_mode) begin
      watchdog_enable_bit_r <= pwdata[rwdt_pkg::RWDT_MODE_EN_BIT];
    end
  end

  // idle two run enable, must be set before entering idle two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_two_run_enable_r <= rwdt_pkg::RWDT_I2RUN_RST;
    end else if (wr_mode) begin
      idle_two_run_enable_r <= pwdata[rwdt_pkg::RWDT_MODE_I2RUN_BIT];
    end
  end

  // reset link bit, no reset by default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_link_bit_r <= rwdt_pkg::RWDT_RLINK_RST;
    end else if (wr_mode) begin
      reset_link_bit_r <= pwdata[rwdt_pkg::RWDT_MODE_RLINK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // enable state

  // two-step disable, one-step enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_state_r <= rwdt_pkg::RWDT_RUNNING;
    end else begin
      case (en_state_r)
        rwdt_pkg::RWDT_RUNNING: begin
          if (cmd_disable && !watchdog_enable_bit_r) begin
            en_state_r <= rwdt_pkg::RWDT_DISABLED;
          end
        end
        rwdt_pkg::RWDT_DISABLED: begin
          if (wr_mode && pwdata[rwdt_pkg::RWDT_MODE_EN_BIT]) begin
            en_state_r <= rwdt_pkg::RWDT_RUNNING;
          end
        end
        default: begin
          en_state_r <= rwdt_pkg::RWDT_RUNNING;
        end
      endcase
    end
  end

  assign active = (en_state_r == rwdt_pkg::RWDT_RUNNING);

  ////////////////////////////////////////////////////////////////////////////////
  // counter control

  // low-power modes that freeze the count
  assign deep_halt = idle_level_one || stop_mode;
  assign idle_two_halt = idle_level_two && !idle_two_run_enable_r;
  assign halted = deep_halt || idle_two_halt;

  // count only while enabled, awake and not resetting
  assign wif.run = active && !halted && !wif.sys_rst;
  // clear code restarts; a disabled watchdog holds zero
  assign wif.clear = cmd_clear || !active;
  assign wif.tsel = timeout_select_r;
  // overflow reaches the reset only when linked
  assign wif.rst_trig = wif.overflow && reset_link_bit_r && !wif.rst_busy;

  rwdt_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cif(wif)
  );

  rwdt_rst_stretch u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .rif(wif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // nmi and internal reset

  // one-cycle non-maskable request on each overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= wif.overflow;
    end
  end

  assign watchdog_nmi_request = nmi_r;
  // separate internal net, pin level untouched
  assign internal_reset = wif.sys_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  // sticky events, a new event wins over a write-one clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_nxt & ~pwdata[rwdt_pkg::RWDT_ST_W-1:0];
    end
    if (wif.overflow) begin
      stat_nxt[rwdt_pkg::RWDT_ST_OVF_BIT] = 1'b1;
    end
    if (wif.rst_trig) begin
      stat_nxt[rwdt_pkg::RWDT_ST_RST_BIT] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= rwdt_pkg::RWDT_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // mask value after this edge
  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = pwdata[rwdt_pkg::RWDT_ST_W-1:0];
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= rwdt_pkg::RWDT_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // level interrupt from a flop, follows status and mask in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  // mode control fields packed into a bus word, unused bits zero
  function automatic logic [31:0] rwdt_mode_word(
    input logic en,
    input logic [1:0] tsel,
    input logic i2run,
    input logic rlink
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[rwdt_pkg::RWDT_MODE_EN_BIT] = en;
    w[rwdt_pkg::RWDT_MODE_TSEL_LO +: 2] = tsel;
    w[rwdt_pkg::RWDT_MODE_I2RUN_BIT] = i2run;
    w[rwdt_pkg::RWDT_MODE_RLINK_BIT] = rlink;
    return w;
  endfunction

  // live state: internal reset, halted, active
  assign state_word = {29'h0000_0000, internal_reset, halted, active};

  // word presented for a read of the addressed register
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      rwdt_pkg::RWDT_OFF_MODE: begin
        rd_word = rwdt_mode_word(watchdog_enable_bit_r, timeout_select_r, idle_two_run_enable_r, reset_link_bit_r);
      end
      rwdt_pkg::RWDT_OFF_STAT: begin
        rd_word = {{(32-rwdt_pkg::RWDT_ST_W){1'b0}}, stat_r};
      end
      rwdt_pkg::RWDT_OFF_MASK: begin
        rd_word = {{(32-rwdt_pkg::RWDT_ST_W){1'b0}}, mask_r};
      end
      rwdt_pkg::RWDT_OFF_STATE: begin
        rd_word = state_word;
      end
      rwdt_pkg::RWDT_OFF_COUNT: begin
        rd_word = {{(32-rwdt_pkg::RWDT_CNT_W){1'b0}}, wif.count};
      end
      default: begin
        rd_word = 32'h0000_0000; // command register reads as zero
      end
    endcase
  end

  // captured in the setup cycle, stands during the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata = prdata_r;

endmodule

// File: tb/rwdt_top_assertions.sv
// Purpose: port-level checks of the watchdog top
// Assumes: single pclk domain, presetn active low
// Notes: bound into rwdt_top
`timescale 1ns/100ps
module rwdt_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rwdt_pkg::RWDT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic idle_level_one,
  input wire logic idle_level_two,
  input wire logic stop_mode,
  input wire logic watchdog_nmi_request,
  input wire logic irq,
  input wire logic internal_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] len_r;
  logic acc;
  logic hit;
  ////////////////////////////////////////////////////////////////////////////////
  // access phase and decode of the six mapped words
  assign acc = psel & penable;
  assign hit = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
  // counts cycles of a running internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= 6'h00;
    end else begin
      len_r <= internal_reset ? len_r + 6'h01 : 6'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_no_wait: assert property (pready) else $error("pready low");
  a_slverr_unmapped: assert property (acc && !hit |-> pslverr) else $error("no slverr on hole");
  a_slverr_mapped: assert property (acc && hit |-> !pslverr) else $error("slverr on register");
  a_cmd_reads_zero: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
    else $error("command word read nonzero");
  a_nmi_one_cycle: assert property (watchdog_nmi_request |=> !watchdog_nmi_request)
    else $error("nmi longer than a cycle");
  a_rst_with_nmi: assert property ($rose(internal_reset) |-> watchdog_nmi_request)
    else $error("reset without overflow");
  a_rst_len_min: assert property ($fell(internal_reset) |-> len_r >= 6'd22)
    else $error("internal reset too short");
  a_rst_len_max: assert property (internal_reset |-> len_r < 6'd29)
    else $error("internal reset too long");
  a_halt_no_nmi: assert property ((idle_level_one || stop_mode) [*4] |-> !watchdog_nmi_request)
    else $error("nmi while halted");
  a_irq_has_cause: assert property ($rose(irq) |-> watchdog_nmi_request || $past(acc && pwrite && paddr == 8'h0c))
    else $error("irq rose without cause");
  c_nmi: cover property (watchdog_nmi_request);
  c_rst_done: cover property ($fell(internal_reset));
  c_slverr: cover property (acc && pslverr);
endmodule

bind rwdt_top rwdt_top_assertions i_rwdt_top_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .idle_level_one(idle_level_one), .idle_level_two(idle_level_two),
  .stop_mode(stop_mode), .watchdog_nmi_request(watchdog_nmi_request), .irq(irq),
  .internal_reset(internal_reset));

// File: tb/rwdt_core_model.sv
// Purpose: processor side that takes the nmi and the internal reset
// Assumes: both inputs on pclk
// Notes: records nmi count and the length of each internal reset
`timescale 1ns/100ps
module rwdt_core_model (
  input wire logic pclk,
  input wire logic watchdog_nmi_request,
  input wire logic internal_reset,
  output int nmi_cnt,
  output int rst_cnt,
  output int rst_len
);
  int run;
  initial begin
    nmi_cnt = 0;
    rst_cnt = 0;
    rst_len = 0;
    run = 0;
  end
  // tally nmi pulses, time each reset
  always @(posedge pclk) begin
    if (watchdog_nmi_request === 1'b1) nmi_cnt <= nmi_cnt + 1;
    if (internal_reset === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      rst_len <= run;
      rst_cnt <= rst_cnt + 1;
      run <= 0;
    end
  end
endmodule

// File: tb/tb_runaway_watchdog_timer.sv
// Purpose: self-checking bench of the watchdog over apb
// Assumes: 200 MHz pclk, shortest timeout select
// Notes: two overflows, about 66k cycles in all
`timescale 1ns/100ps
module tb_runaway_watchdog_timer;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, c0;
  logic pready, pslverr, err_q, watchdog_nmi_request, irq, internal_reset;
  logic idle_level_one, idle_level_two, stop_mode;
  logic [7:0] cmd_v;
  int n_errors, cmp_count, cyc_cnt, n, nmi_cnt, rst_cnt, rst_len;
  rwdt_top i_rwdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_level_one(idle_level_one), .idle_level_two(idle_level_two), .stop_mode(stop_mode),
    .watchdog_nmi_request(watchdog_nmi_request), .irq(irq), .internal_reset(internal_reset));
  rwdt_core_model i_rwdt_core_model (.pclk(pclk), .watchdog_nmi_request(watchdog_nmi_request),
    .internal_reset(internal_reset), .nmi_cnt(nmi_cnt), .rst_cnt(rst_cnt), .rst_len(rst_len));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 80000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, setup then access until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd_q, e);
  endtask
  // hold low-power inputs, see whether the count moves
  task automatic halt_chk(input logic [2:0] h, input logic grow);
    {idle_level_one, stop_mode, idle_level_two} <= h;
    xfer(1'b0, rwdt_pkg::RWDT_OFF_COUNT, 32'h0);
    c0 = rd_q;
    xfer(1'b0, rwdt_pkg::RWDT_OFF_COUNT, 32'h0);
    chk("count moves", rd_q > c0, grow);
    {idle_level_one, stop_mode, idle_level_two} <= 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {idle_level_one, idle_level_two, stop_mode} = 3'h0;
    n_errors = 0;
    cmp_count = 0;
    cyc_cnt = 0;
    n = $urandom(7);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // values after reset
    rdc(rwdt_pkg::RWDT_OFF_MODE, 32'h80, "mode");
    rdc(rwdt_pkg::RWDT_OFF_STAT, 32'h0, "status");
    rdc(rwdt_pkg::RWDT_OFF_MASK, 32'h0, "mask");
    rdc(rwdt_pkg::RWDT_OFF_STATE, 32'h1, "state");
    rdc(rwdt_pkg::RWDT_OFF_CMD, 32'h0, "command");
    rdc(8'h18, 32'h0, "hole");
    chk("slverr", err_q, 1'b1);
    halt_chk(3'b000, 1'b1);
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'h4e);
    xfer(1'b0, rwdt_pkg::RWDT_OFF_COUNT, 32'h0);
    chk("count cleared", rd_q < 32'd8, 1'b1);
    // random other codes leave the count running
    for (int k = 0; k < 4; k++) begin
      c0 = rd_q;
      cmd_v = 8'($urandom());
      if (cmd_v == 8'h4e || cmd_v == 8'hb1) cmd_v = 8'h00;
      xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, {24'h0, cmd_v});
      xfer(1'b0, rwdt_pkg::RWDT_OFF_COUNT, 32'h0);
      chk("count kept", rd_q > c0, 1'b1);
    end
    halt_chk(3'b100, 1'b0);
    halt_chk(3'b010, 1'b0);
    halt_chk(3'b001, 1'b0);
    // first overflow, nmi only
    xfer(1'b1, rwdt_pkg::RWDT_OFF_MASK, 32'h3);
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'h4e);
    n = 0;
    while (watchdog_nmi_request !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("nmi delay", n >= 32766 && n <= 32772, 1'b1);
    chk("irq set", irq, 1'b1);
    rdc(rwdt_pkg::RWDT_OFF_STAT, 32'h1, "status ovf");
    xfer(1'b1, rwdt_pkg::RWDT_OFF_STAT, 32'h1);
    @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    chk("no reset", rst_cnt, 32'h0);
    // disable needs enable low then code, a clear is sent between them
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'hb1);
    rdc(rwdt_pkg::RWDT_OFF_STATE, 32'h1, "code alone");
    xfer(1'b1, rwdt_pkg::RWDT_OFF_MODE, 32'h0);
    rdc(rwdt_pkg::RWDT_OFF_STATE, 32'h1, "bit alone");
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'h4e);
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'hb1);
    rdc(rwdt_pkg::RWDT_OFF_STATE, 32'h0, "disabled");
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, rwdt_pkg::RWDT_OFF_MODE, 32'(k) << 5);
      rdc(rwdt_pkg::RWDT_OFF_MODE, 32'(k) << 5, "timeout select");
    end
    rdc(rwdt_pkg::RWDT_OFF_COUNT, 32'h0, "count held");
    xfer(1'b1, rwdt_pkg::RWDT_OFF_MODE, 32'h0a);
    xfer(1'b1, rwdt_pkg::RWDT_OFF_MODE, 32'h8a);
    rdc(rwdt_pkg::RWDT_OFF_STATE, 32'h1, "re-enabled");
    halt_chk(3'b001, 1'b1);
    // second overflow drives the internal reset
    xfer(1'b1, rwdt_pkg::RWDT_OFF_CMD, 32'h4e);
    n = 0;
    while (rst_cnt == 0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("reset length", rst_len >= 22 && rst_len <= 29, 1'b1);
    rdc(rwdt_pkg::RWDT_OFF_STAT, 32'h3, "status rst");
    chk("presetn untouched", presetn, 1'b1);
    rdc(rwdt_pkg::RWDT_OFF_MODE, 32'h8a, "mode kept");
    chk("nmi count", nmi_cnt, 32'd2);
    print_verdict();
  end
endmodule
